// *** shared/bdm_pkg.sv ***
// constants and types shared by the banked data memory addressing block
package bdm_pkg;
	localparam int ADDR_W = 12;
	localparam int FILE_W = 8;
	localparam int BANK_W = 4;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 4096;
	// bank used by the access window for file addresses below and above the split
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	// one bit per bank, set where the bank has storage behind it
	localparam logic [15:0] IMPL_BANKS = 16'h8003;
	localparam logic [3:0] BANK_SEL_RESET = 4'h0;
	// register byte offsets on the bus
	localparam logic [31:0] OFS_BANK_SEL = 32'h0000_0000;
	localparam logic [31:0] OFS_LAST_ADDR = 32'h0000_0004;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
	// status register fields
	localparam int STAT_UNIMPL_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	// operations offered to the execute core
	typedef enum logic [1:0] {
		OP_DIRECT_RD,
		OP_DIRECT_WR,
		OP_FULL_MOVE,
		OP_LOAD_BANK
	} bdm_op_t;
endpackage : bdm_pkg

// *** shared/bdm_mem_if.sv ***
// port between the address former and its byte store
interface bdm_mem_if;
	import bdm_pkg::*;
	logic we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport store (input we, input addr, input wdata, output rdata);
endinterface : bdm_mem_if

// *** design/bdm_ram.sv ***
// static byte store of the whole data space, registered read
module bdm_ram import bdm_pkg::*; (
	input wire logic clk,
	bdm_mem_if.store mem
);
	logic [DATA_W-1:0] cells [MEM_DEPTH];
	logic [DATA_W-1:0] rdata;

	// write on strobe, read the addressed byte every cycle
	always_ff @(posedge clk) begin
		if (mem.we) begin
			cells[mem.addr] <= mem.wdata;
		end
		rdata <= cells[mem.addr];
	end

	assign mem.rdata = rdata;
endmodule : bdm_ram

// *** design/bdm_core.sv ***
// banked data memory address former with bank selector and bus registers
// Behaviour
// - a 256-location access window joins the low 128 bytes of bank 0 and the high 128 bytes of bank 15.
// - the access-select bit of each direct read or write picks the selected bank or the access window.
// - with access-select 0 the last low-half location is followed directly by the first high-half location.
// - the high half of the window reaches the special function regs without touching the bank selector.
// - data memory is split into up to sixteen banks and direct accesses with access-select 1 use the bank now selected.
// - the low four bits of the bank selector are the top four bits of the 12-bit banked address.
// - the upper four bits of the bank selector read as zero and writes to them are discarded.
// - reads of an unimplemented bank return zero and writes to it change nothing.
// - an unimplemented-bank access still reports flags from the zero value read back.
// - each bank spans 256 bytes and all data memory is static storage.
// - the full-address move ignores the bank selector and uses its own 12-bit addresses.
// - the load-bank instruction writes a literal into the bank selector.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
module bdm_core import bdm_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic [1:0] hresp,
	input wire logic op_valid,
	input wire bdm_op_t op_kind,
	input wire logic op_access_sel,
	input wire logic [FILE_W-1:0] op_file_addr,
	input wire logic [DATA_W-1:0] op_wdata,
	input wire logic [ADDR_W-1:0] op_src_addr,
	input wire logic [ADDR_W-1:0] op_dst_addr,
	input wire logic [DATA_W-1:0] op_literal,
	output logic op_ready,
	output logic op_done,
	output logic [DATA_W-1:0] op_rdata,
	output logic op_zero,
	output logic op_unimpl
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_MOVE
	} bdm_state_t;

	// direct address: selected bank, or the access window split on file bit 7
	function automatic logic [ADDR_W-1:0] form_addr(input logic acc, input logic [BANK_W-1:0] bank,
		input logic [FILE_W-1:0] file_addr);
		if (acc) begin
			form_addr = {bank, file_addr};
		end else if (file_addr[7]) begin
			form_addr = {ACCESS_HIGH_BANK, file_addr};
		end else begin
			form_addr = {ACCESS_LOW_BANK, file_addr};
		end
	endfunction : form_addr

	// true where the bank holding this address has storage
	function automatic logic bank_impl(input logic [ADDR_W-1:0] addr);
		bank_impl = IMPL_BANKS[addr[ADDR_W-1:FILE_W]];
	endfunction : bank_impl

	bdm_mem_if mem_bus ();

	// one byte-wide static store of the full space, 256 bytes per bank
	bdm_ram u_ram (
		.clk(clk),
		.mem(mem_bus.ctrl)
	);

	bdm_state_t state, next_state;
	logic [BANK_W-1:0] bank_sel, next_bank_sel;
	logic [ADDR_W-1:0] last_addr, next_last_addr;
	logic [ADDR_W-1:0] dst_addr, next_dst_addr;
	logic rd_impl, next_rd_impl;
	logic [DATA_W-1:0] result, next_result;
	logic done, next_done;
	logic zero, next_zero;
	logic unimpl, next_unimpl;
	logic ahb_wr_pend, next_ahb_wr_pend;
	logic [31:0] ahb_addr, next_ahb_addr;
	logic [31:0] rdata_q, next_rdata_q;
	logic op_take;
	logic ahb_take;
	logic mem_we_c;
	logic [ADDR_W-1:0] mem_addr_c;
	logic [DATA_W-1:0] mem_wdata_c;
	logic [DATA_W-1:0] rd_byte;

	assign op_take = op_valid && (state == ST_IDLE);
	assign ahb_take = hsel && hready && (htrans == HTRANS_NONSEQ);
	// unimplemented bank reads back as zero
	assign rd_byte = rd_impl ? mem_bus.rdata : 8'h00;

	// operation sequencing and memory port drive
	always_comb begin
		next_state = state;
		next_last_addr = last_addr;
		next_dst_addr = dst_addr;
		next_rd_impl = rd_impl;
		next_result = result;
		next_done = 1'b0;
		next_zero = zero;
		next_unimpl = unimpl;
		mem_we_c = 1'b0;
		mem_addr_c = form_addr(op_access_sel, bank_sel, op_file_addr);
		mem_wdata_c = op_wdata;
		unique case (state)
			ST_IDLE: begin
				if (op_take) begin
					unique case (op_kind)
						OP_DIRECT_RD: begin
							next_rd_impl = bank_impl(mem_addr_c);
							next_unimpl = !bank_impl(mem_addr_c);
							next_last_addr = mem_addr_c;
							next_state = ST_READ;
						end
						OP_DIRECT_WR: begin
							mem_we_c = bank_impl(mem_addr_c);
							next_unimpl = !bank_impl(mem_addr_c);
							next_last_addr = mem_addr_c;
							next_done = 1'b1;
						end
						OP_FULL_MOVE: begin
							mem_addr_c = op_src_addr;
							next_rd_impl = bank_impl(op_src_addr);
							next_dst_addr = op_dst_addr;
							next_last_addr = op_src_addr;
							next_state = ST_MOVE;
						end
						OP_LOAD_BANK: begin
							next_done = 1'b1;
						end
					endcase
				end
			end
			ST_READ: begin
				// flags come from the value read, zero for an empty bank
				next_result = rd_byte;
				next_zero = (rd_byte == 8'h00);
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
			ST_MOVE: begin
				mem_addr_c = dst_addr;
				mem_wdata_c = rd_byte;
				mem_we_c = bank_impl(dst_addr);
				next_unimpl = !rd_impl || !bank_impl(dst_addr);
				next_last_addr = dst_addr;
				next_result = rd_byte;
				next_zero = (rd_byte == 8'h00);
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
		endcase
	end

	assign mem_bus.we = mem_we_c;
	assign mem_bus.addr = mem_addr_c;
	assign mem_bus.wdata = mem_wdata_c;

	// bus slave: address phase capture, bank selector writes, read data
	always_comb begin
		next_ahb_wr_pend = ahb_take && hwrite;
		next_ahb_addr = ahb_take ? haddr : ahb_addr;
		next_bank_sel = bank_sel;
		if (ahb_wr_pend && (ahb_addr == OFS_BANK_SEL)) begin
			next_bank_sel = hwdata[BANK_W-1:0];
		end
		if (op_take && (op_kind == OP_LOAD_BANK)) begin
			next_bank_sel = op_literal[BANK_W-1:0];
		end
		next_rdata_q = rdata_q;
		if (ahb_take && !hwrite) begin
			unique case (haddr)
				OFS_BANK_SEL: next_rdata_q = {28'h0000000, next_bank_sel};
				OFS_LAST_ADDR: next_rdata_q = {20'h00000, next_last_addr};
				OFS_STATUS: begin
					next_rdata_q = 32'h0000_0000;
					next_rdata_q[STAT_UNIMPL_BIT] = next_unimpl;
					next_rdata_q[STAT_BUSY_BIT] = (next_state != ST_IDLE);
				end
				default: next_rdata_q = 32'h0000_0000;
			endcase
		end
	end

	// state registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= ST_IDLE;
			bank_sel <= BANK_SEL_RESET;
			last_addr <= 12'h000;
			dst_addr <= 12'h000;
			rd_impl <= 1'b0;
			result <= 8'h00;
			done <= 1'b0;
			zero <= 1'b0;
			unimpl <= 1'b0;
			ahb_wr_pend <= 1'b0;
			ahb_addr <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
		end else begin
			state <= next_state;
			bank_sel <= next_bank_sel;
			last_addr <= next_last_addr;
			dst_addr <= next_dst_addr;
			rd_impl <= next_rd_impl;
			result <= next_result;
			done <= next_done;
			zero <= next_zero;
			unimpl <= next_unimpl;
			ahb_wr_pend <= next_ahb_wr_pend;
			ahb_addr <= next_ahb_addr;
			rdata_q <= next_rdata_q;
		end
	end

	// outputs: zero-wait bus slave, registered results
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = rdata_q;
	assign op_ready = (state == ST_IDLE);
	assign op_done = done;
	assign op_rdata = result;
	assign op_zero = zero;
	assign op_unimpl = unimpl;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// window low half lands in bank 0
	access_low_a: assert property ((op_take && op_kind inside {OP_DIRECT_RD, OP_DIRECT_WR} && !op_access_sel
		&& !op_file_addr[7]) |-> (mem_addr_c == {4'h0, op_file_addr}))
		else $error("window low half not mapped to bank 0");

	// window high half lands in bank 15 regardless of selector
	access_high_a: assert property ((op_take && op_kind inside {OP_DIRECT_RD, OP_DIRECT_WR} && !op_access_sel
		&& op_file_addr[7]) |-> (mem_addr_c == {4'hF, op_file_addr}))
		else $error("window high half not mapped to bank 15");

	// banked access uses selector above file address
	banked_addr_a: assert property ((op_take && op_kind inside {OP_DIRECT_RD, OP_DIRECT_WR} && op_access_sel)
		|-> (mem_addr_c == {bank_sel, op_file_addr}))
		else $error("banked address not formed from selector");

	// selector upper bits read as zero
	sel_upper_a: assert property ((ahb_take && !hwrite && haddr == OFS_BANK_SEL) |=> (hrdata[31:4] == 28'h0000000))
		else $error("selector upper bits not zero");

	// bus write to selector takes effect unless a load-bank overrides it
	sel_write_a: assert property ((ahb_wr_pend && ahb_addr == OFS_BANK_SEL && !(op_take && op_kind == OP_LOAD_BANK))
		|=> (bank_sel == $past(hwdata[3:0])))
		else $error("selector write lost");

	// load-bank literal reaches the selector
	load_bank_a: assert property ((op_take && op_kind == OP_LOAD_BANK) |=> (bank_sel == $past(op_literal[3:0])
		&& op_done))
		else $error("load bank literal not stored");

	// no store into an empty bank
	unimpl_write_a: assert property (mem_we_c |-> bank_impl(mem_addr_c))
		else $error("write reached an unimplemented bank");

	// empty bank read gives zero and zero flag two cycles later
	unimpl_read_a: assert property ((op_take && op_kind == OP_DIRECT_RD && !bank_impl(mem_addr_c))
		|-> ##2 (op_done && op_rdata == 8'h00 && op_zero && op_unimpl))
		else $error("unimplemented read not zero");

	// full move reads source then writes destination
	move_addr_a: assert property ((op_take && op_kind == OP_FULL_MOVE) |-> (mem_addr_c == op_src_addr)
		##1 (state == ST_MOVE && mem_addr_c == $past(op_dst_addr)) ##1 op_done)
		else $error("full move addresses wrong");
endmodule : bdm_core

// *** bench/bdm_exec_model.sv ***
// stand-in for the execute core that issues one operation at a time
module bdm_exec_model import bdm_pkg::*; (
	input wire logic clk,
	input wire logic op_ready,
	input wire logic op_done,
	output logic op_valid,
	output bdm_op_t op_kind,
	output logic op_access_sel,
	output logic [FILE_W-1:0] op_file_addr,
	output logic [DATA_W-1:0] op_wdata,
	output logic [ADDR_W-1:0] op_src_addr,
	output logic [ADDR_W-1:0] op_dst_addr,
	output logic [DATA_W-1:0] op_literal
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle request lines at time zero
	initial begin
		op_valid = 1'h0;
		op_kind = OP_DIRECT_RD;
		op_access_sel = 1'h0;
		op_file_addr = 8'h00;
		op_wdata = 8'h00;
		op_src_addr = 12'h000;
		op_dst_addr = 12'h000;
		op_literal = 8'h00;
	end
	// hold the request until taken, scramble released data, then wait for done
	task automatic run(input bdm_op_t k, input logic a, input logic [7:0] f, d, input logic [11:0] s, t,
		output logic ok);
		int n = 0;
		@(posedge clk);
		op_valid <= 1'h1;
		op_kind <= k;
		op_access_sel <= a;
		op_file_addr <= f;
		op_wdata <= d;
		op_literal <= d;
		op_src_addr <= s;
		op_dst_addr <= t;
		do begin
			@(posedge clk);
			n++;
		end while (op_ready !== 1'h1 && n < 50);
		op_valid <= 1'h0;
		op_wdata <= ~d; // released data no longer shows the old value
		op_file_addr <= ~f;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (op_done !== 1'h1 && n < 8);
		ok = (op_done === 1'h1);
	endtask : run
endmodule : bdm_exec_model

// *** bench/tb_banked_data_memory_addressing.sv ***
// self-checking bench for the banked address former
module tb_banked_data_memory_addressing import bdm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, hsel, hwrite, hreadyout, ok;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize;
	logic op_valid, op_access_sel, op_ready, op_done, op_zero, op_unimpl;
	bdm_op_t op_kind;
	logic [7:0] op_file_addr, op_wdata, op_literal, op_rdata;
	logic [11:0] op_src_addr, op_dst_addr;
	int errors, cmp_count;
	bdm_core u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .op_valid(op_valid), .op_kind(op_kind), .op_access_sel(op_access_sel),
		.op_file_addr(op_file_addr), .op_wdata(op_wdata), .op_src_addr(op_src_addr), .op_dst_addr(op_dst_addr),
		.op_literal(op_literal), .op_ready(op_ready), .op_done(op_done), .op_rdata(op_rdata),
		.op_zero(op_zero), .op_unimpl(op_unimpl));
	bdm_exec_model u_core (.clk(clk), .op_ready(op_ready), .op_done(op_done), .op_valid(op_valid),
		.op_kind(op_kind), .op_access_sel(op_access_sel), .op_file_addr(op_file_addr), .op_wdata(op_wdata),
		.op_src_addr(op_src_addr), .op_dst_addr(op_dst_addr), .op_literal(op_literal));
	// free-running core clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// one single-word bus transfer: address phase, then data phase
	// waits for ready with no limit of its own: only the watchdog ends a hung wait
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= a;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'h1);
		q = hrdata;
		chk("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
	endtask : bus
	task automatic op(input bdm_op_t k, input logic a, input logic [7:0] f, d, input logic [11:0] s, t);
		u_core.run(k, a, f, d, s, t, ok);
		chk("op_done", {31'h0, ok}, 32'h1);
	endtask : op
	task automatic t_regs();
		bus(1'h0, OFS_BANK_SEL, 32'h0, r);
		chk("bank_sel reset", r, 32'h0);
		bus(1'h1, OFS_BANK_SEL, 32'hFFFF_FFFF, r);
		bus(1'h0, OFS_BANK_SEL, 32'h0, r);
		chk("bank_sel upper", r, 32'h0000_000F);
		bus(1'h0, 32'h0000_0010, 32'h0, r);
		chk("unmapped", r, 32'h0);
		$display("test regs done");
	endtask : t_regs
	// window writes with bank 15 selected, read back by full-address moves
	task automatic t_window();
		logic [7:0] f[4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
		logic [11:0] m[4] = '{12'h000, 12'h07F, 12'hF80, 12'hFFF};
		for (int i = 0; i < 4; i++) begin
			op(OP_DIRECT_WR, 1'h0, f[i], f[i] ^ 8'h5A, 12'h0, 12'h0);
			bus(1'h0, OFS_LAST_ADDR, 32'h0, r);
			chk("window addr", r, {20'h0, m[i]});
		end
		for (int i = 0; i < 4; i++) begin
			op(OP_FULL_MOVE, 1'h0, 8'h00, 8'h00, m[i], 12'h100);
			chk("moved byte", {24'h0, op_rdata}, {24'h0, f[i] ^ 8'h5A});
		end
		// selector moved off bank 15 so only the window can reach the high half
		op(OP_LOAD_BANK, 1'h0, 8'h00, 8'h00, 12'h0, 12'h0);
		op(OP_DIRECT_RD, 1'h0, 8'h80, 8'h00, 12'h0, 12'h0);
		chk("high half", {24'h0, op_rdata}, 32'h0000_00DA);
		bus(1'h0, OFS_BANK_SEL, 32'h0, r);
		chk("selector kept", r, 32'h0);
		$display("test window done");
	endtask : t_window
	task automatic t_bank();
		op(OP_LOAD_BANK, 1'h0, 8'h00, 8'hF1, 12'h0, 12'h0);
		bus(1'h0, OFS_BANK_SEL, 32'h0, r);
		chk("load bank", r, 32'h0000_0001);
		op(OP_DIRECT_WR, 1'h1, 8'h33, 8'h3C, 12'h0, 12'h0);
		bus(1'h0, OFS_LAST_ADDR, 32'h0, r);
		chk("banked addr", r, 32'h0000_0133);
		op(OP_DIRECT_RD, 1'h1, 8'h33, 8'h00, 12'h0, 12'h0);
		chk("banked read", {22'h0, op_zero, op_unimpl, op_rdata}, 32'h0000_003C);
		$display("test bank done");
	endtask : t_bank
	task automatic t_unimpl();
		op(OP_LOAD_BANK, 1'h0, 8'h00, 8'h05, 12'h0, 12'h0);
		op(OP_DIRECT_WR, 1'h1, 8'h10, 8'h77, 12'h0, 12'h0);
		op(OP_DIRECT_RD, 1'h1, 8'h10, 8'h00, 12'h0, 12'h0);
		chk("unimpl read", {22'h0, op_zero, op_unimpl, op_rdata}, 32'h0000_0300);
		bus(1'h0, OFS_STATUS, 32'h0, r);
		chk("status unimpl", {31'h0, r[STAT_UNIMPL_BIT]}, 32'h1);
		op(OP_FULL_MOVE, 1'h0, 8'h00, 8'h00, 12'h510, 12'h002);
		chk("dropped write", {24'h0, op_rdata}, 32'h0);
		op(OP_LOAD_BANK, 1'h0, 8'h00, 8'h00, 12'h0, 12'h0);
		op(OP_DIRECT_RD, 1'h1, 8'h7F, 8'h00, 12'h0, 12'h0);
		chk("bank 0 read", {24'h0, op_rdata}, 32'h0000_0025);
		$display("test unimpl done");
	endtask : t_unimpl
	// reset, then the scenarios in turn
	initial begin
		errors = 0;
		cmp_count = 0;
		rstn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		t_regs();
		t_window();
		t_bank();
		t_unimpl();
		end_sim();
	end
	// watchdog well past the expected run length
	initial begin
		#40000;
		errors++;
		end_sim();
	end
endmodule : tb_banked_data_memory_addressing
